// File: hw/srx_pkg.sv
/*
  Package for the receiver status readout: register offsets, bit positions,
  reset values and the carrier structs.
  Assumes a 16-bit register word per address and one 20 MHz system clock.
*/
package srx_pkg;

  // register offsets
  localparam logic [7:0] OFS_INTERP   = 8'h18;
  localparam logic [7:0] OFS_RX_STATE = 8'h59;
  localparam logic [7:0] OFS_L_LOW    = 8'h5A;
  localparam logic [7:0] OFS_L_MID    = 8'h5B;
  localparam logic [7:0] OFS_L_HIGH   = 8'h5C;
  localparam logic [7:0] OFS_R_LOW    = 8'h5D;
  localparam logic [7:0] OFS_R_MID    = 8'h5E;
  localparam logic [7:0] OFS_R_HIGH   = 8'h5F;
  localparam logic [7:0] OFS_IN_CTRL  = 8'h30;

  // bit positions
  localparam int BIT_MUTE_STATE  = 2;
  localparam int BIT_SEL_REPORT  = 3;
  localparam int BIT_BURST_SEEN  = 2;
  localparam int BIT_BIPHASE_ERR = 1;
  localparam int BIT_LOCKED      = 0;
  localparam int BIT_SEL_CTRL    = 0;
  localparam int BIT_AUTOMUTE_EN = 2;
  localparam int CS_CONSUMER_BIT = 0;

  // reset values of the host-written controls
  localparam logic RST_SEL_CTRL    = 1'b0;
  localparam logic RST_AUTOMUTE_EN = 1'b1;

  // channel-status block geometry
  localparam int           CS_BITS = 40;
  localparam logic [5:0]   CS_LAST = 6'h27;

  // decoder condition flags, same clock domain
  typedef struct packed {
    logic locked;
    logic biphase_err;
    logic burst_seen;
  } srx_rx_flags_t;

  // one recovered channel-status bit from the decoder
  typedef struct packed {
    logic valid;
    logic block_start;
    logic right;
    logic chan_status_bit;
  } srx_cs_beat_t;

endpackage

// File: hw/srx_cs_collector.sv
/*
  Collects the 40 channel-status bits of one subframe and commits them as
  a whole block when its consumer bit is zero. Assumes beats come from
  decoder logic on the same clock.
*/
module srx_cs_collector (
  input  wire logic                      i_clk_sys,  // system clock
  input  wire logic                      i_rst_n,    // sync reset, low
  input  wire srx_pkg::srx_cs_beat_t     i_beat,     // bit for this channel
  output logic [srx_pkg::CS_BITS-1:0]    o_block,    // last whole consumer block
  output logic                           o_commit    // pulse on update
);
  import srx_pkg::*;

  typedef enum logic {COL_IDLE, COL_FILL} srx_col_state_t;

  srx_col_state_t          state;
  logic [5:0]              idx;
  logic [CS_BITS-1:0]      acc;
  logic [5:0]              next_idx;
  logic [CS_BITS-1:0]      next_acc;

  // bit n lands at position n, so every field keeps its place
  always_comb begin
    next_idx = i_beat.block_start ? 6'h00 : idx;
    next_acc = acc;
    // an index past the block (idle after bit 39) writes nothing
    if (next_idx < 6'(CS_BITS)) begin
      next_acc[next_idx] = i_beat.chan_status_bit;
    end
  end

  // a start bit always resynchronises, even mid block
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state <= COL_IDLE;
      idx   <= 6'h00;
      acc   <= '0;
    end else if (i_beat.valid) begin
      case (state)
        COL_IDLE: begin
          if (i_beat.block_start) begin
            acc   <= next_acc;
            idx   <= 6'h01;
            state <= COL_FILL;
          end
        end
        COL_FILL: begin
          acc <= next_acc;
          idx <= next_idx + 6'h01;
          if (next_idx == CS_LAST) begin
            state <= COL_IDLE;
          end
        end
        default: state <= COL_IDLE;
      endcase
    end
  end

  // commit only full consumer blocks; a torn block is never visible
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_block  <= '0;
      o_commit <= 1'b0;
    end else begin
      o_commit <= 1'b0;
      if (i_beat.valid && state == COL_FILL && next_idx == CS_LAST
          && !next_acc[CS_CONSUMER_BIT]) begin
        o_block  <= next_acc;
        o_commit <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  property p_block_stable;
    !o_commit |-> o_block == $past(o_block);
  endproperty
  a_block_stable: assert property (p_block_stable)
    else $error("status block changed without a commit");

  property p_consumer_zero;
    o_commit |-> !o_block[CS_CONSUMER_BIT];
  endproperty
  a_consumer_zero: assert property (p_consumer_zero)
    else $error("committed block has consumer bit set");

  property p_commit_after_last;
    o_commit |-> $past(i_beat.valid) && $past(idx) == CS_LAST;
  endproperty
  a_commit_after_last: assert property (p_commit_after_last)
    else $error("commit without the fortieth bit");

  c_commit: cover property (o_commit);
endmodule

// File: hw/srx_status_readout.sv
/*
  Status readout of the serial audio receiver: mute state, receiver state,
  input selection and the captured left/right channel-status blocks, read
  through a simple addressed register port. Also holds the host-written
  input-select and burst auto-mute controls.
  Assumes decoder flags and status bits arrive on i_clk_sys; the two audio
  input pins are asynchronous and are synchronised here. A read is answered
  one edge after its strobe and the word then stands until the next read.
  Status flags are live levels, not sticky: a host that must catch a short
  burst or bit error has to poll faster than the event lasts.
*/
module srx_status_readout (
  input  wire logic                  i_clk_sys,     // 20 MHz system clock
  input  wire logic                  i_rst_n,       // sync reset, low
  input  wire logic                  i_audio_input_a, // first audio pin
  input  wire logic                  i_audio_input_b, // second audio pin
  input  wire srx_pkg::srx_rx_flags_t i_rx,         // decoder flags
  input  wire srx_pkg::srx_cs_beat_t i_cs,          // channel-status bits
  input  wire logic                  i_mute_done,   // mute sequence done
  input  wire logic                  i_rd_en,       // read strobe
  input  wire logic [7:0]            i_rd_addr,     // read address
  input  wire logic                  i_wr_en,       // write strobe
  input  wire logic [7:0]            i_wr_addr,     // write address
  input  wire logic [15:0]           i_wr_data,     // write data
  output logic [15:0]                o_rd_data,     // read data
  output logic                       o_rd_valid,    // read data valid
  output logic                       o_slicer_in,   // selected stream
  output logic                       o_automute_req // mute request
);
  import srx_pkg::*;

  logic [1:0]          pin_s1;
  logic [1:0]          pin_s2;
  logic                input_select_ctrl;
  logic                burst_automute_enable;
  logic                mute_state;
  logic                input_select_report;
  srx_rx_flags_t       rx_q;
  logic [CS_BITS-1:0]  cs_blk [2];
  logic [1:0]          cs_commit;
  logic [15:0]         next_rd_data;

  // write decode of the control word; shared by the register and its checks
  function automatic logic ctrl_hit(input logic en, input logic [7:0] addr);
    return en && (addr == OFS_IN_CTRL);
  endfunction

  // one 16-bit register word out of a 40-bit status block; the top word
  // carries bits 39..32 only, so its upper byte always reads zero
  function automatic logic [15:0] cs_part(input logic [CS_BITS-1:0] blk,
                                          input logic [1:0]         part);
    logic [15:0] w;
    case (part)
      2'h0:    w = blk[15:0];
      2'h1:    w = blk[31:16];
      2'h2:    w = {8'h00, blk[39:32]};
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  // two-stage synchronisers on the asynchronous audio pins
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pin_s1 <= 2'h0;
      pin_s2 <= 2'h0;
    end else begin
      pin_s1 <= {i_audio_input_b, i_audio_input_a};
      pin_s2 <= pin_s1;
    end
  end

  // host-written input control; reserved bits are dropped, so a read-back
  // shows only the two controls and never stale reserved values
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      input_select_ctrl     <= RST_SEL_CTRL;
      burst_automute_enable <= RST_AUTOMUTE_EN;
    end else if (ctrl_hit(i_wr_en, i_wr_addr)) begin
      input_select_ctrl     <= i_wr_data[BIT_SEL_CTRL];
      burst_automute_enable <= i_wr_data[BIT_AUTOMUTE_EN];
    end
  end

  // slicer input mux, after the synchronisers only
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_slicer_in <= 1'b0;
    end else begin
      o_slicer_in <= input_select_ctrl ? pin_s2[1] : pin_s2[0];
    end
  end

  // auto-mute request to the mute sequencer
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_automute_req <= 1'b0;
    end else begin
      o_automute_req <= burst_automute_enable & i_rx.burst_seen;
    end
  end

  // live status flags; levels, so no sticky behaviour
  // select report trails the control by one edge, as the slicer mux does
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      mute_state          <= 1'b0;
      rx_q                <= '0;
      input_select_report <= RST_SEL_CTRL;
    end else begin
      mute_state          <= i_mute_done;
      rx_q                <= i_rx;
      input_select_report <= input_select_ctrl;
    end
  end

  // one collector per subframe, routed by the right-channel flag
  // the start marker goes to both; only the gated valid makes it count
  for (genvar g = 0; g < 2; g++) begin : g_chan
    srx_cs_collector u_col (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_beat    (srx_cs_beat_t'{valid:           i_cs.valid && (i_cs.right == (g == 1)),
                                 block_start:     i_cs.block_start,
                                 right:           i_cs.right,
                                 chan_status_bit: i_cs.chan_status_bit}),
      .o_block   (cs_blk[g]),
      .o_commit  (cs_commit[g])
    );
  end

  // read mux; unmapped offsets and reserved bits read zero
  always_comb begin
    next_rd_data = 16'h0000;
    case (i_rd_addr)
      OFS_INTERP: begin
        next_rd_data[BIT_MUTE_STATE] = mute_state;
      end
      OFS_RX_STATE: begin
        next_rd_data[BIT_SEL_REPORT]  = input_select_report;
        next_rd_data[BIT_BURST_SEEN]  = rx_q.burst_seen;
        next_rd_data[BIT_BIPHASE_ERR] = rx_q.biphase_err;
        next_rd_data[BIT_LOCKED]      = rx_q.locked;
      end
      OFS_L_LOW:  next_rd_data = cs_part(cs_blk[0], 2'h0);
      OFS_L_MID:  next_rd_data = cs_part(cs_blk[0], 2'h1);
      OFS_L_HIGH: next_rd_data = cs_part(cs_blk[0], 2'h2);
      OFS_R_LOW:  next_rd_data = cs_part(cs_blk[1], 2'h0);
      OFS_R_MID:  next_rd_data = cs_part(cs_blk[1], 2'h1);
      OFS_R_HIGH: next_rd_data = cs_part(cs_blk[1], 2'h2);
      OFS_IN_CTRL: begin
        next_rd_data[BIT_SEL_CTRL]    = input_select_ctrl;
        next_rd_data[BIT_AUTOMUTE_EN] = burst_automute_enable;
      end
      default: next_rd_data = 16'h0000;
    endcase
  end

  // read answer one cycle after the strobe; data held until next read
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_rd_data  <= 16'h0000;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        o_rd_data <= next_rd_data;
      end
    end
  end

  // checks sample on the system clock and sleep while reset is held
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  property p_mute_read;
    i_rd_en && i_rd_addr == OFS_INTERP
      |=> o_rd_data[BIT_MUTE_STATE] == $past(i_mute_done, 2);
  endproperty
  a_mute_read: assert property (p_mute_read)
    else $error("mute state read does not match sequencer");

  property p_sel_report;
    i_rd_en && i_rd_addr == OFS_RX_STATE
      |=> o_rd_data[BIT_SEL_REPORT] == $past(input_select_ctrl, 2);
  endproperty
  a_sel_report: assert property (p_sel_report)
    else $error("select report does not follow control");

  property p_burst_read;
    i_rd_en && i_rd_addr == OFS_RX_STATE
      |=> o_rd_data[BIT_BURST_SEEN] == $past(i_rx.burst_seen, 2);
  endproperty
  a_burst_read: assert property (p_burst_read)
    else $error("burst bit wrong");

  property p_err_read;
    i_rd_en && i_rd_addr == OFS_RX_STATE
      |=> o_rd_data[BIT_BIPHASE_ERR] == $past(i_rx.biphase_err, 2);
  endproperty
  a_err_read: assert property (p_err_read)
    else $error("bi-phase error bit wrong");

  property p_lock_read;
    i_rd_en && i_rd_addr == OFS_RX_STATE
      |=> o_rd_data[BIT_LOCKED] == $past(i_rx.locked, 2)
          && o_rd_data[15:4] == 12'h000;
  endproperty
  a_lock_read: assert property (p_lock_read)
    else $error("lock bit or reserved bits wrong");

  property p_left_low;
    i_rd_en && i_rd_addr == OFS_L_LOW |=> o_rd_data == $past(cs_blk[0][15:0]);
  endproperty
  a_left_low: assert property (p_left_low)
    else $error("left low word wrong");

  property p_right_high;
    i_rd_en && i_rd_addr == OFS_R_HIGH
      |=> o_rd_data == {8'h00, $past(cs_blk[1][39:32])};
  endproperty
  a_right_high: assert property (p_right_high)
    else $error("right high word wrong");

  property p_slicer_path;
    ##1 (input_select_ctrl == $past(input_select_ctrl)) [*3]
      |-> o_slicer_in == (input_select_ctrl ? $past(i_audio_input_b, 3)
                                            : $past(i_audio_input_a, 3));
  endproperty
  a_slicer_path: assert property (p_slicer_path)
    else $error("slicer does not carry the selected pin");

  property p_automute;
    burst_automute_enable && i_rx.burst_seen |=> o_automute_req;
  endproperty
  a_automute: assert property (p_automute)
    else $error("burst did not request mute");

  property p_no_automute;
    !burst_automute_enable || !i_rx.burst_seen |=> !o_automute_req;
  endproperty
  a_no_automute: assert property (p_no_automute)
    else $error("mute requested without enabled burst");

  // register words of the captured blocks, read straight from the store
  property p_left_mid;
    i_rd_en && i_rd_addr == OFS_L_MID
      |=> o_rd_data == $past(cs_blk[0][31:16]);
  endproperty
  a_left_mid: assert property (p_left_mid)
    else $error("left mid word wrong");

  property p_left_high;
    i_rd_en && i_rd_addr == OFS_L_HIGH
      |=> o_rd_data == {8'h00, $past(cs_blk[0][39:32])};
  endproperty
  a_left_high: assert property (p_left_high)
    else $error("left high word wrong");

  property p_right_low;
    i_rd_en && i_rd_addr == OFS_R_LOW
      |=> o_rd_data == $past(cs_blk[1][15:0]);
  endproperty
  a_right_low: assert property (p_right_low)
    else $error("right low word wrong");

  property p_right_mid;
    i_rd_en && i_rd_addr == OFS_R_MID
      |=> o_rd_data == $past(cs_blk[1][31:16]);
  endproperty
  a_right_mid: assert property (p_right_mid)
    else $error("right mid word wrong");

  // reserved bits of the mute word must never leak anything
  property p_interp_reserved;
    i_rd_en && i_rd_addr == OFS_INTERP
      |=> o_rd_data[15:3] == 13'h0000 && o_rd_data[1:0] == 2'h0;
  endproperty
  a_interp_reserved: assert property (p_interp_reserved)
    else $error("reserved bits of mute word set");

  property p_mute_track;
    mute_state == $past(i_mute_done);
  endproperty
  a_mute_track: assert property (p_mute_track)
    else $error("mute state does not follow sequencer");

  // the reported input is the one the slicer really carries
  property p_report_follows;
    input_select_report == $past(input_select_ctrl);
  endproperty
  a_report_follows: assert property (p_report_follows)
    else $error("select report lags more than one edge");

  property p_report_matches;
    o_slicer_in == (input_select_report ? $past(pin_s2[1]) : $past(pin_s2[0]));
  endproperty
  a_report_matches: assert property (p_report_matches)
    else $error("reported input differs from slicer source");

  // control word: writes land, other cycles leave it alone, reads echo it
  property p_sel_write;
    ctrl_hit(i_wr_en, i_wr_addr)
      |=> input_select_ctrl == $past(i_wr_data[BIT_SEL_CTRL]);
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("select write did not land");

  property p_automute_write;
    ctrl_hit(i_wr_en, i_wr_addr)
      |=> burst_automute_enable == $past(i_wr_data[BIT_AUTOMUTE_EN]);
  endproperty
  a_automute_write: assert property (p_automute_write)
    else $error("auto-mute enable write did not land");

  property p_ctrl_hold;
    !ctrl_hit(i_wr_en, i_wr_addr)
      |=> $stable(input_select_ctrl) && $stable(burst_automute_enable);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("control changed without a write");

  property p_ctrl_readback;
    i_rd_en && i_rd_addr == OFS_IN_CTRL
      |=> o_rd_data == {13'h0000, $past(burst_automute_enable), 1'b0,
                        $past(input_select_ctrl)};
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback)
    else $error("control read-back wrong");

  // a read word stands untouched until the next read strobe
  property p_rd_hold;
    !i_rd_en |=> $stable(o_rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed between reads");

  c_rx_locked_read: cover property (i_rd_en && i_rd_addr == OFS_RX_STATE
                                    ##1 o_rd_data[BIT_LOCKED]);
  c_left_commit:    cover property (cs_commit[0]);
  c_right_commit:   cover property (cs_commit[1]);
  c_automute:       cover property (o_automute_req);
endmodule

// File: bench/srx_audio_src.sv
/*
  Audio source model: hands recovered channel-status bits to the readout
  as decoder beats, bit 0 first with the block-start marker.
  Assumes the bench clock; beats change only at falling edges.
*/
module srx_audio_src (
  input  wire logic           i_clk_sys, // system clock
  output srx_pkg::srx_cs_beat_t o_beat   // one status bit per beat
);
  timeunit 1ns;
  timeprecision 1ps;
  import srx_pkg::*;
  initial o_beat = '0;
  // bits 0..39 in order; gap idles between beats model a slow source.
  // the data line toggles when idle so a stale bit is never mistaken for data
  task automatic send(input logic [39:0] blk, input logic right, input int gap);
    for (int n = 0; n < 40; n++) begin
      @(negedge i_clk_sys);
      o_beat = '{1'b1, n == 0, right, blk[n]};
      for (int g = 0; g < gap; g++) begin
        @(negedge i_clk_sys);
        o_beat.valid = 1'b0;
        o_beat.chan_status_bit = ~o_beat.chan_status_bit;
      end
    end
    @(negedge i_clk_sys);
    o_beat.valid = 1'b0;
  endtask
endmodule

// File: bench/srx_status_readout_tb_top.sv
/*
  Self-checking bench of the status readout: random decoder flags, mute
  state, controls and pins, plus whole channel-status blocks from the source
  model. Assumes the register port and latencies of the design notes.
*/
module srx_status_readout_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import srx_pkg::*;
  logic          clk = 1'b0;
  logic          rst_n, pin_a, pin_b, mute_done, rd_en, wr_en, sel, amen;
  logic [7:0]    rd_addr, wr_addr;
  logic [15:0]   wr_data, rd_data;
  logic          rd_valid, slicer_in, automute_req;
  srx_rx_flags_t rx;
  srx_cs_beat_t  cs;
  logic [39:0]   lblk, rblk, nblk;
  int            fails, total_checks, seed;

  always #25 clk = ~clk;

  srx_audio_src i_src (.i_clk_sys(clk), .o_beat(cs));
  srx_status_readout i_dut (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_audio_input_a(pin_a),
    .i_audio_input_b(pin_b), .i_rx(rx), .i_cs(cs), .i_mute_done(mute_done),
    .i_rd_en(rd_en), .i_rd_addr(rd_addr), .i_wr_en(wr_en), .i_wr_addr(wr_addr),
    .i_wr_data(wr_data), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .o_slicer_in(slicer_in), .o_automute_req(automute_req));

  // expected receiver state word
  function automatic logic [15:0] exp_rx(input srx_rx_flags_t f, input logic s);
    return {12'h000, s, f.burst_seen, f.biphase_err, f.locked};
  endfunction
  // expected word k (low, mid, high) of a stored block
  function automatic logic [15:0] cs_word(input logic [39:0] b, input int k);
    return (k == 0) ? b[15:0] : (k == 1) ? b[31:16] : {8'h00, b[39:32]};
  endfunction

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one read; the answer is waited for under a bound
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    int n;
    n = 0;
    @(negedge clk);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    while (rd_valid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    if (n == 4) begin
      fails++;
      conclude();
    end
    check($sformatf("read %h", a), exp, rd_data);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clk);
    wr_en = 1'b0;
  endtask
  // all three words of one channel
  task automatic rd_blk(input logic [39:0] b, input logic [7:0] base);
    for (int k = 0; k < 3; k++)
      rd(base + 8'(k), cs_word(b, k));
  endtask
  function automatic logic [39:0] rnd_blk();
    logic [39:0] b;
    b[31:0] = 32'($random(seed));
    b[39:32] = 8'($random(seed));
    b[0] = 1'b0;
    return b;
  endfunction

  initial begin
    seed = 58;
    fails = 0;
    total_checks = 0;
    {rst_n, pin_a, pin_b, mute_done, rd_en, wr_en, sel} = '0;
    amen = 1'b1;
    {rd_addr, wr_addr, wr_data} = '0;
    rx = '0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    // reset values, unmapped offset, ignored write to a read-only word
    rd(OFS_RX_STATE, 16'h0000);
    rd(OFS_IN_CTRL, 16'h0004);
    rd(8'h00, 16'h0000);
    wr(OFS_RX_STATE, 16'hFFFF);
    rd(OFS_IN_CTRL, 16'h0004);
    rd_blk(40'h0, OFS_L_LOW);
    rd_blk(40'h0, OFS_R_LOW);
    // random flags, mute state, controls and pins
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      rx = srx_rx_flags_t'($random(seed));
      mute_done = 1'($random(seed));
      {pin_a, pin_b, sel, amen} = 4'($random(seed));
      wr(OFS_IN_CTRL, {13'h0000, amen, 1'b0, sel});
      rd(OFS_RX_STATE, exp_rx(rx, sel));
      rd(OFS_INTERP, {13'h0000, mute_done, 2'b00});
      check("automute", {15'h0, amen & rx.burst_seen}, {15'h0, automute_req});
      check("slicer", {15'h0, sel ? pin_b : pin_a}, {15'h0, slicer_in});
    end
    // whole blocks, back-to-back beats and slow beats
    lblk = rnd_blk();
    rblk = rnd_blk();
    i_src.send(lblk, 1'b0, 0);
    i_src.send(rblk, 1'b1, 2);
    rd_blk(lblk, OFS_L_LOW);
    rd_blk(rblk, OFS_R_LOW);
    // a block with the consumer bit set is dropped
    nblk = rnd_blk();
    nblk[0] = 1'b1;
    i_src.send(nblk, 1'b0, 0);
    rd_blk(lblk, OFS_L_LOW);
    // reads during a block in flight see only the previous block
    nblk = rnd_blk();
    fork
      i_src.send(nblk, 1'b0, 1);
    join_none
    repeat (20) @(negedge clk);
    rd_blk(lblk, OFS_L_LOW);
    wait fork;
    rd_blk(nblk, OFS_L_LOW);
    rd_blk(rblk, OFS_R_LOW);
    conclude();
  end
endmodule
